// *** sbc_params.svh ***
// Register offsets, field positions, reset values and counts for standby control.
`ifndef SBC_PARAMS_SVH
`define SBC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SBC_ADDR_W 4
`define SBC_OFS_PSC 4'h0
`define SBC_OFS_MODE 4'h4
`define SBC_OFS_WAIT 4'h8
`define SBC_OFS_STAT 4'hC

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SBC_PSC_TRIG 1
`define SBC_PSC_MASKABLE 4
`define SBC_PSC_NMI0 5
`define SBC_PSC_NMI1 6
`define SBC_STAT_OSC_OK 4
`define SBC_STAT_BUSY 5

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define SBC_PSC_RST 1'b0
`define SBC_MODE_RST 2'h0
`define SBC_WAIT_SEL_RST 3'h6
`define SBC_STAB_BASE_EXP 10
`define SBC_RESP_OKAY 2'h0
`define SBC_RESP_SLVERR 2'h2

`endif

// *** sbc_pkg.sv ***
// Types shared by the standby control block.
package sbc_pkg;

  // Operating state of the device clock control.
  typedef enum logic [2:0] {
    SBC_RUN = 3'b000,
    SBC_HALT = 3'b001,
    SBC_IDLE_LIGHT = 3'b010,
    SBC_IDLE_DEEP = 3'b011,
    SBC_STOP = 3'b100,
    SBC_IDLE_SUB = 3'b101,
    SBC_OSC_WAIT = 3'b110,
    SBC_STAB = 3'b111
  } sbc_state_e;

  // Encoding of the two mode-select bits.
  typedef enum logic [1:0] {
    SBC_SEL_LIGHT_IDLE = 2'b00,
    SBC_SEL_STOP = 2'b01,
    SBC_SEL_DEEP_IDLE = 2'b10,
    SBC_SEL_SUB_IDLE = 2'b11
  } sbc_mode_sel_e;

endpackage

// *** sbc_stab_counter.sv ***
// Oscillation stabilization wait counter with a power-of-two length.
`timescale 1ns/1ns
`include "sbc_params.svh"
module sbc_stab_counter import sbc_pkg::*; #(
  parameter int BASE_EXP = `SBC_STAB_BASE_EXP,
  parameter int CNT_W = BASE_EXP + 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [2:0] exp_sel_i,
  output logic busy_o,
  output logic done_o
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] limit;
  logic [2:0] sel_q;
  logic [4:0] exp_tot;
  logic [CNT_W-1:0] one_w;

  // The wait lasts 2 to the power of (base + select) cycles.
  assign one_w = CNT_W'(1);
  assign exp_tot = 5'(BASE_EXP) + {2'b00, sel_q};
  assign limit = (one_w << exp_tot) - one_w;
  assign done_o = busy_o && (cnt == limit);

  // Select is captured at start so a rewrite cannot stretch a running wait.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt <= '0;
      busy_o <= 1'b0;
      sel_q <= `SBC_WAIT_SEL_RST;
    end else if (start_i) begin
      cnt <= '0;
      busy_o <= 1'b1;
      sel_q <= exp_sel_i;
    end else if (done_o) begin
      busy_o <= 1'b0;
    end else if (busy_o) begin
      cnt <= cnt + one_w;
    end
  end

  // The count never passes the programmed end.
  chk_cnt_bound: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    busy_o |-> cnt <= limit)
    else $error("stabilization counter ran past its limit");

endmodule // sbc_stab_counter

// *** sbc_axil_slave.sv ***
// AXI4-Lite slave front end producing register write strobes and sampling read data.
`timescale 1ns/1ns
`include "sbc_params.svh"
module sbc_axil_slave import sbc_pkg::*; #(
  parameter int ADDR_W = `SBC_ADDR_W
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic wr_en_o,
  output logic [ADDR_W-1:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  input wire logic wr_ok_i,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_ok_i
);

  logic aw_held;
  logic w_held;
  logic [3:0] strb_q;

  // Address and data are taken in either order and held until both exist.
  assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_held && !s_axi_bvalid_o;
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign wr_en_o = aw_held && w_held && !s_axi_bvalid_o && strb_q[0];

  // Write channel holding registers and response.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr_o <= '0;
      wr_data_o <= 8'h00;
      strb_q <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `SBC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held <= 1'b1;
        wr_addr_o <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held <= 1'b1;
        wr_data_o <= s_axi_wdata_i[7:0];
        strb_q <= s_axi_wstrb_i;
      end
      if (aw_held && w_held && !s_axi_bvalid_o) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_ok_i ? `SBC_RESP_OKAY : `SBC_RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // Read data is sampled from the live decode at the address handshake.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `SBC_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_ok_i ? rd_data_i : 32'h0000_0000;
      s_axi_rresp_o <= rd_ok_i ? `SBC_RESP_OKAY : `SBC_RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

endmodule // sbc_axil_slave

// *** sbc_standby_ctrl.sv ***
// Standby mode entry, wake decision and oscillator stabilization control.
//
// Overview of operation
// - Any interrupt releases halt, masks ignored.
// - Mask bits written with trigger are discarded.
// - Mode bits act only while trigger is set.
// - Wait counts only once oscillator runs.
// - Wait after reset is 2^16 cycles.
// - Pending unmasked interrupt ends idle at once.
// - Masked interrupt class never releases idle.
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
`include "sbc_params.svh"
module sbc_standby_ctrl import sbc_pkg::*; #(
  parameter int ADDR_W = `SBC_ADDR_W,
  parameter int BASE_EXP = `SBC_STAB_BASE_EXP
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic halt_req_i,
  input wire logic irq_maskable_i,
  input wire logic irq_nonmask_zero_i,
  input wire logic irq_nonmask_one_i,
  input wire logic osc_running_i,
  output logic osc_en_o,
  output logic cpu_clk_en_o,
  output logic periph_clk_en_o,
  output logic stab_wait_o
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  sbc_state_e state;
  sbc_state_e next_state;
  logic [1:0] mode_select;
  logic [2:0] wait_select;
  logic standby_trigger;
  logic wake_mask_maskable;
  logic wake_mask_nonmask_zero;
  logic wake_mask_nonmask_one;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_ok;
  logic rd_ok;
  logic [31:0] rd_data;
  logic [7:0] psc_rd;
  logic [7:0] stat_rd;
  logic psc_wr;
  logic mode_wr;
  logic wait_wr;
  logic trig_set;
  logic any_irq;
  logic unmasked_irq;
  logic in_idle;
  logic release_idle;
  logic release_halt;
  logic osc_meta;
  logic osc_s2;
  logic osc_s3;
  logic osc_ok;
  logic cnt_start;
  logic cnt_busy;
  logic cnt_done;

  // --------------------------------------------------------------------
  // Register bus
  // --------------------------------------------------------------------

  // Bus handshakes live in the slave; this module owns decode and state.
  sbc_axil_slave #(
    .ADDR_W(ADDR_W)
  ) u_bus (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .s_axi_awaddr_i(s_axi_awaddr_i),
    .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wdata_i(s_axi_wdata_i),
    .s_axi_wstrb_i(s_axi_wstrb_i),
    .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i),
    .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i),
    .wr_en_o(wr_en),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data),
    .wr_ok_i(wr_ok),
    .rd_data_i(rd_data),
    .rd_ok_i(rd_ok)
  );

  // Write decode; the status word is read only, so writes to it fail.
  assign psc_wr = wr_en && (wr_addr == `SBC_OFS_PSC);
  assign mode_wr = wr_en && (wr_addr == `SBC_OFS_MODE);
  assign wait_wr = wr_en && (wr_addr == `SBC_OFS_WAIT);
  assign wr_ok = (wr_addr == `SBC_OFS_PSC) || (wr_addr == `SBC_OFS_MODE) ||
                 (wr_addr == `SBC_OFS_WAIT);

  // Read decode; reserved bits read as zero.
  assign psc_rd = {1'b0, wake_mask_nonmask_one, wake_mask_nonmask_zero,
                   wake_mask_maskable, 2'b00, standby_trigger, 1'b0};
  assign stat_rd = {2'b00, cnt_busy, osc_ok, 1'b0, state};
  assign rd_ok = (s_axi_araddr_i == `SBC_OFS_PSC) ||
                 (s_axi_araddr_i == `SBC_OFS_MODE) ||
                 (s_axi_araddr_i == `SBC_OFS_WAIT) ||
                 (s_axi_araddr_i == `SBC_OFS_STAT);
  assign rd_data =
    (s_axi_araddr_i == `SBC_OFS_PSC) ? {24'h00_0000, psc_rd} :
    (s_axi_araddr_i == `SBC_OFS_MODE) ? {30'h0000_0000, mode_select} :
    (s_axi_araddr_i == `SBC_OFS_WAIT) ? {29'h0000_0000, wait_select} :
    {24'h00_0000, stat_rd};

  // --------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------

  // Trigger sets only from run; hardware clears it when standby ends.
  assign trig_set = psc_wr && wr_data[`SBC_PSC_TRIG] && (state == SBC_RUN);

  // Mask fields are kept when the same write sets the trigger, so a
  // careless single write cannot arm a mask while entering standby.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wake_mask_maskable <= `SBC_PSC_RST;
      wake_mask_nonmask_zero <= `SBC_PSC_RST;
      wake_mask_nonmask_one <= `SBC_PSC_RST;
    end else if (psc_wr && !wr_data[`SBC_PSC_TRIG]) begin
      wake_mask_maskable <= wr_data[`SBC_PSC_MASKABLE];
      wake_mask_nonmask_zero <= wr_data[`SBC_PSC_NMI0];
      wake_mask_nonmask_one <= wr_data[`SBC_PSC_NMI1];
    end
  end

  // A set in the release cycle wins over the hardware clear.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      standby_trigger <= `SBC_PSC_RST;
    end else if (trig_set) begin
      standby_trigger <= 1'b1;
    end else if (release_idle || (state == SBC_STOP && unmasked_irq)) begin
      standby_trigger <= 1'b0;
    end
  end

  // Mode and wait select; only the low bits are stored.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mode_select <= `SBC_MODE_RST;
      wait_select <= `SBC_WAIT_SEL_RST;
    end else begin
      if (mode_wr) begin
        mode_select <= wr_data[1:0];
      end
      if (wait_wr) begin
        wait_select <= wr_data[2:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // Oscillator running input
  // --------------------------------------------------------------------

  // The oscillator flag comes from another domain; a change is accepted
  // only once the second and third stages agree, filtering one glitch.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      osc_meta <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
      osc_ok <= 1'b0;
    end else begin
      osc_meta <= osc_running_i;
      osc_s2 <= osc_meta;
      osc_s3 <= osc_s2;
      if (osc_s2 == osc_s3) begin
        osc_ok <= osc_s3;
      end
    end
  end

  // --------------------------------------------------------------------
  // Wake decision
  // --------------------------------------------------------------------

  // Halt ignores every mask; idle levels and stop honour them.
  assign any_irq = irq_maskable_i || irq_nonmask_zero_i ||
                   irq_nonmask_one_i;
  assign unmasked_irq = (irq_maskable_i && !wake_mask_maskable) ||
                        (irq_nonmask_zero_i && !wake_mask_nonmask_zero) ||
                        (irq_nonmask_one_i && !wake_mask_nonmask_one);
  assign in_idle = (state == SBC_IDLE_LIGHT) || (state == SBC_IDLE_DEEP) ||
                   (state == SBC_IDLE_SUB);
  assign release_halt = (state == SBC_HALT) && any_irq;
  assign release_idle = in_idle && unmasked_irq;
  assign cnt_start = (state == SBC_OSC_WAIT) && osc_ok;

  // --------------------------------------------------------------------
  // State machine
  // --------------------------------------------------------------------

  // A pending request is seen the cycle after entry, so it leaves at once.
  always_comb begin
    next_state = state;
    unique case (state)
      SBC_RUN: begin
        if (standby_trigger) begin
          unique case (sbc_mode_sel_e'(mode_select))
            SBC_SEL_LIGHT_IDLE: next_state = SBC_IDLE_LIGHT;
            SBC_SEL_STOP: next_state = SBC_STOP;
            SBC_SEL_DEEP_IDLE: next_state = SBC_IDLE_DEEP;
            SBC_SEL_SUB_IDLE: next_state = SBC_IDLE_SUB;
          endcase
        end else if (halt_req_i) begin
          next_state = SBC_HALT;
        end
      end
      SBC_HALT: begin
        if (release_halt) begin
          next_state = SBC_RUN;
        end
      end
      SBC_IDLE_LIGHT, SBC_IDLE_DEEP, SBC_IDLE_SUB: begin
        if (release_idle) begin
          next_state = SBC_RUN;
        end
      end
      SBC_STOP: begin
        if (unmasked_irq) begin
          next_state = SBC_OSC_WAIT;
        end
      end
      SBC_OSC_WAIT: begin
        if (osc_ok) begin
          next_state = SBC_STAB;
        end
      end
      SBC_STAB: begin
        if (cnt_done) begin
          next_state = SBC_RUN;
        end
      end
    endcase
  end

  // Reset behaves like a stop release: wait for the oscillator, then count.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state <= SBC_OSC_WAIT;
    end else begin
      state <= next_state;
    end
  end

  // The wait length follows the select register, six after reset.
  sbc_stab_counter #(
    .BASE_EXP(BASE_EXP)
  ) u_stab (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .start_i(cnt_start),
    .exp_sel_i(wait_select),
    .busy_o(cnt_busy),
    .done_o(cnt_done)
  );

  // --------------------------------------------------------------------
  // Clock control outputs
  // --------------------------------------------------------------------
  assign osc_en_o = (state != SBC_STOP);
  assign cpu_clk_en_o = (state == SBC_RUN);
  assign periph_clk_en_o = (state == SBC_RUN) || (state == SBC_HALT);
  assign stab_wait_o = cnt_busy;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  chk_halt_any_wake: assert property (
    (state == SBC_HALT) && any_irq |=> state == SBC_RUN)
    else $error("halt not left on an interrupt");

  chk_mask_discard: assert property (
    psc_wr && wr_data[`SBC_PSC_TRIG] |=>
      wake_mask_maskable == $past(wake_mask_maskable) &&
      wake_mask_nonmask_zero == $past(wake_mask_nonmask_zero) &&
      wake_mask_nonmask_one == $past(wake_mask_nonmask_one))
    else $error("mask bits changed with trigger write");

  chk_mode_gate: assert property (
    (state == SBC_RUN) && !standby_trigger && !halt_req_i |=>
      state == SBC_RUN)
    else $error("standby entered without trigger");

  chk_osc_first: assert property (
    (state == SBC_OSC_WAIT) && !osc_ok |=> !cnt_busy)
    else $error("wait counted before oscillator ran");

  chk_reset_sel: assert property (
    $past(rst_i) |-> wait_select == 3'h6 && state == SBC_OSC_WAIT)
    else $error("reset wait select not six");

  chk_pend_leave: assert property (
    in_idle && unmasked_irq |=> state == SBC_RUN && !standby_trigger &&
      cpu_clk_en_o)
    else $error("idle not left on pending interrupt");

  chk_masked_stay: assert property (
    in_idle && !unmasked_irq |=> state == $past(state))
    else $error("idle left on masked interrupt");

  chk_trig_clear: assert property (
    release_idle && !trig_set |=> !standby_trigger && cpu_clk_en_o)
    else $error("trigger not cleared at release");

  chk_stop_osc: assert property (
    (state == SBC_RUN) && standby_trigger &&
      (mode_select == SBC_SEL_STOP) |=> !osc_en_o)
    else $error("stop did not halt oscillator");

endmodule // sbc_standby_ctrl

// *** standby_mode_entry_control_tb.sv ***
// Self-checking testbench for the standby mode entry control block.
`timescale 1ns/1ns
`include "sbc_params.svh"
module standby_mode_entry_control_tb import sbc_pkg::*;;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] s_axi_awaddr_i = 4'h0;
  logic [3:0] s_axi_araddr_i = 4'h0;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic s_axi_awvalid_i = 1'b0;
  logic s_axi_wvalid_i = 1'b0;
  logic s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0;
  logic s_axi_rready_i = 1'b0;
  logic halt_req_i = 1'b0;
  logic irq_maskable_i = 1'b0;
  logic irq_nonmask_zero_i = 1'b0;
  logic irq_nonmask_one_i = 1'b0;
  logic osc_running_i = 1'b1;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic s_axi_rvalid_o, osc_en_o, cpu_clk_en_o, periph_clk_en_o;
  logic stab_wait_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o;
  logic [3:0] strb = 4'hF;
  logic [1:0] last_rresp = 2'b00;
  int mismatches = 0;
  int checked = 0;
  int stab_cnt = 0;

  // A zero exponent base keeps the reset wait at 64 cycles.
  sbc_standby_ctrl #(.BASE_EXP(0)) dut (
    .sys_clk_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .halt_req_i,
    .irq_maskable_i, .irq_nonmask_zero_i, .irq_nonmask_one_i,
    .osc_running_i, .osc_en_o, .cpu_clk_en_o, .periph_clk_en_o,
    .stab_wait_o
  );

  // The clock toggles every half period of 5 ns.
  always #5 sys_clk_i = ~sys_clk_i;

  // Counts the cycles in which the stabilization counter is busy.
  always @(posedge sys_clk_i) begin
    if (stab_wait_o === 1'b1) begin
      stab_cnt <= stab_cnt + 1;
    end
  end

  // ---------------------------------------------------------------
  // Expectation functions, compares and bus tasks
  // ---------------------------------------------------------------
  // Only an interrupt class whose mask bit is clear can wake idle.
  function automatic logic wakes(logic [2:0] m, logic [2:0] v);
    return |(v & ~m);
  endfunction

  // State code that each mode-select value should lead to.
  function automatic logic [2:0] sel_state(logic [1:0] s);
    case (s)
      2'h0: return SBC_IDLE_LIGHT;
      2'h1: return SBC_STOP;
      2'h2: return SBC_IDLE_DEEP;
      default: return SBC_IDLE_SUB;
    endcase
  endfunction

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_word({31'h0, got}, {31'h0, exp});
  endtask

  task automatic complete_run;
    if (mismatches == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Offers address and data together; each is released once taken.
  task automatic axi_wr(input logic [3:0] a, input logic [7:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {24'h0, d};
    s_axi_wstrb_i <= strb;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
      n++;
    end while (s_axi_bvalid_o !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    r = s_axi_bresp_o;
  endtask

  // Ready lines stay high between transfers, so back-to-back calls never
  // lower and raise them again within one time step.

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    int n;
    n = 0;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
      n++;
    end while (s_axi_rvalid_o !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    d = s_axi_rdata_o;
    last_rresp = s_axi_rresp_o;
  endtask

  task automatic set_irq(input logic [2:0] v);
    {irq_nonmask_one_i, irq_nonmask_zero_i, irq_maskable_i} <= v;
  endtask

  // Bounded wait for the CPU clock to come back.
  task automatic wait_run(input int lim);
    int n;
    n = 0;
    while (cpu_clk_en_o !== 1'b1 && n < lim) begin
      @(posedge sys_clk_i);
      n++;
    end
    check_bit(cpu_clk_en_o, 1'b1);
  endtask

  // ---------------------------------------------------------------
  // Watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6000) @(posedge sys_clk_i);
    mismatches++;
    complete_run();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r, sel;
    logic [2:0] m, v;
    logic pend;
    int base;
    void'($urandom(32'h9df8994f));
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    // Reset values, read before the reset wait has ended.
    axi_rd(`SBC_OFS_PSC, d);
    check_word(d, 32'h0);
    axi_rd(`SBC_OFS_WAIT, d);
    check_word(d, 32'h6);
    check_word(32'(last_rresp), 32'(`SBC_RESP_OKAY));
    wait_run(200);
    check_word(stab_cnt, 32'd64);
    // The status word is read-only, so a write is refused.
    axi_wr(`SBC_OFS_STAT, 8'h07, r);
    check_word(32'(r), 32'(`SBC_RESP_SLVERR));
    // A write without its byte strobe changes nothing.
    strb = 4'h0;
    axi_wr(`SBC_OFS_MODE, 8'h02, r);
    strb = 4'hF;
    check_word(32'(r), 32'(`SBC_RESP_OKAY));
    axi_rd(`SBC_OFS_MODE, d);
    check_word(d, 32'h0);
    // An unmapped word reads as zero with an error response.
    axi_rd(4'h2, d);
    check_word(d, 32'h0);
    check_word(32'(last_rresp), 32'(`SBC_RESP_SLVERR));
    // Random idle entries, masks, pending and late interrupts.
    for (int i = 0; i < 14; i++) begin
      m = 3'($urandom % 7);
      v = 3'($urandom_range(7, 1));
      sel = 2'($urandom % 3);
      if (sel == 2'h1) sel = 2'h3;
      pend = 1'($urandom);
      axi_wr(`SBC_OFS_PSC, {1'b0, m, 4'h0}, r);
      axi_wr(`SBC_OFS_MODE, {6'h0, sel}, r);
      if (pend) set_irq(v);
      axi_wr(`SBC_OFS_PSC, {1'b0, ~m, 4'h2}, r);
      repeat (4) @(posedge sys_clk_i);
      if (!pend) begin
        axi_rd(`SBC_OFS_STAT, d);
        check_word(32'(d[2:0]), 32'(sel_state(sel)));
        set_irq(v);
        repeat (4) @(posedge sys_clk_i);
      end
      check_bit(cpu_clk_en_o, wakes(m, v));
      set_irq(3'h7);
      wait_run(10);
      set_irq(3'h0);
      axi_rd(`SBC_OFS_PSC, d);
      check_word(d, {25'h0, m, 4'h0});
    end
    // Halt ignores the masks: every class is masked here.
    axi_wr(`SBC_OFS_PSC, 8'h70, r);
    halt_req_i <= 1'b1;
    @(posedge sys_clk_i);
    halt_req_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    check_bit(periph_clk_en_o, 1'b1);
    check_bit(cpu_clk_en_o, 1'b0);
    set_irq(3'h4);
    repeat (3) @(posedge sys_clk_i);
    check_bit(cpu_clk_en_o, 1'b1);
    set_irq(3'h0);
    axi_wr(`SBC_OFS_PSC, 8'h00, r);
    // Mode bits alone must not stop anything.
    axi_wr(`SBC_OFS_WAIT, 8'h03, r);
    axi_wr(`SBC_OFS_MODE, 8'h01, r);
    repeat (4) @(posedge sys_clk_i);
    check_bit(cpu_clk_en_o, 1'b1);
    check_bit(osc_en_o, 1'b1);
    // Stop entry, release while the oscillator is still dead.
    axi_wr(`SBC_OFS_PSC, 8'h02, r);
    repeat (2) @(posedge sys_clk_i);
    check_bit(osc_en_o, 1'b0);
    base = stab_cnt;
    osc_running_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    set_irq(3'h2);
    repeat (20) @(posedge sys_clk_i);
    set_irq(3'h0);
    check_word(32'(stab_cnt - base), 32'd0);
    check_bit(cpu_clk_en_o, 1'b0);
    osc_running_i <= 1'b1;
    wait_run(60);
    check_word(32'(stab_cnt - base), 32'd8);
    complete_run();
  end
endmodule // standby_mode_entry_control_tb
